// [adcp_ctrl_power.sv]
// Control-word write path and power-mode controller of the converter.
`timescale 1ns/100ps
`include "adcp_consts.svh"
module adcp_ctrl_power #(
    parameter int CONV_CYCLES      = `ADCP_CONV_CYCLES,
    parameter int WAKE_W           = `ADCP_WAKE_W,
    parameter int SHDN_WAKE_CYCLES = (`ADCP_T_SHDN_WAKE_NS + `ADCP_CLK_NS - 1) / `ADCP_CLK_NS
) (
    // Clock and reset.
    input  wire logic                  core_clk,
    input  wire logic                  reset_n,
    // Parallel host write pins.
    input  wire logic                  cs_n,
    input  wire logic                  wr_n,
    input  wire logic                  word_sel,
    input  wire logic [7:0]            data_lines_lo,
    input  wire logic                  data8_or_byte_sel_line,
    input  wire logic [2:0]            data_lines_hi,
    // Conversion control pins.
    input  wire logic                  convert_start_n,
    input  wire logic                  ref_is_external,
    // Conversion and power status.
    output logic                       busy,
    output logic                       track_mode,
    output logic                       core_powered,
    output logic                       ref_powered,
    output logic                       powerup_pending,
    output adcp_pkg::adcp_pstate_t     power_state,
    output logic [`ADCP_WORD_W-1:0]    ctrl_word
);

    // ****************************************************************
    // Derived counts and parameter checks.
    // ****************************************************************

    localparam int STBY_INT_CYCLES = (`ADCP_T_STBY_INT_NS + `ADCP_CLK_NS - 1) / `ADCP_CLK_NS;
    localparam int STBY_EXT_CYCLES = (`ADCP_T_STBY_EXT_NS + `ADCP_CLK_NS - 1) / `ADCP_CLK_NS;
    localparam int CW              = $clog2(CONV_CYCLES + 1);
    localparam int SW              = 1 + 1 + 1 + 1 + 1 + `ADCP_WORD_W;

    initial begin
        if (CONV_CYCLES < 1) begin
            $error("adcp_ctrl_power: conversion length must be at least one cycle");
        end
        if (SHDN_WAKE_CYCLES < 1 || SHDN_WAKE_CYCLES >= (1 << WAKE_W)) begin
            $error("adcp_ctrl_power: shutdown wake count does not fit the timer");
        end
        if (STBY_INT_CYCLES >= (1 << WAKE_W)) begin
            $error("adcp_ctrl_power: standby wake count does not fit the timer");
        end
    end

    // ****************************************************************
    // Pin synchronisation.
    // ****************************************************************

    logic [SW-1:0]           pins_raw;
    logic [SW-1:0]           pins_s;
    logic                    cs_n_s;
    logic                    wr_n_s;
    logic                    word_sel_s;
    logic                    convert_start_n_n_s;
    logic                    ref_ext_s;
    logic [`ADCP_WORD_W-1:0] data_s;

    assign pins_raw = {cs_n, wr_n, word_sel, convert_start_n, ref_is_external,
                       data_lines_hi, data8_or_byte_sel_line, data_lines_lo};

    adcp_sync #(
        .W   (SW),
        .RST ({1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 12'h000})
    ) u_sync (
        .core_clk  (core_clk),
        .reset_n   (reset_n),
        .pins_in   (pins_raw),
        .pins_sync (pins_s)
    );

    assign {cs_n_s, wr_n_s, word_sel_s, convert_start_n_n_s, ref_ext_s, data_s} = pins_s;

    // ****************************************************************
    // Edge detection, suppressed until the synchroniser has filled.
    // ****************************************************************

    logic [1:0] settle_q;
    logic       settled;
    logic       convert_start_n_prev_q;
    logic       wr_act;
    logic       wr_act_q;
    logic       convert_start_n_rise;
    logic       convert_start_n_fall;
    logic       wr_end;

    assign settled = (settle_q == 2'h3);

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            settle_q <= 2'h0;
        end else if (!settled) begin
            settle_q <= settle_q + 2'h1;
        end
    end

    assign wr_act = ~cs_n_s & ~wr_n_s;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            convert_start_n_prev_q <= 1'b1;
            wr_act_q      <= 1'b0;
        end else begin
            convert_start_n_prev_q <= convert_start_n_n_s;
            wr_act_q      <= wr_act;
        end
    end

    assign convert_start_n_rise = settled & ~convert_start_n_prev_q & convert_start_n_n_s;
    assign convert_start_n_fall = settled & convert_start_n_prev_q & ~convert_start_n_n_s;
    assign wr_end      = settled & wr_act_q & ~wr_act;

    // ****************************************************************
    // Write capture and control-word assembly.
    // ****************************************************************

    logic [`ADCP_WORD_W-1:0] cap_data_q;
    logic                    cap_word_q;
    logic [`ADCP_WORD_W-1:0] ctrl_q;
    logic                    commit_q;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            cap_data_q <= `ADCP_CTRL_RESET;
            cap_word_q <= 1'b1;
        end else if (wr_act) begin
            cap_data_q <= data_s;
            cap_word_q <= word_sel_s;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            ctrl_q <= `ADCP_CTRL_RESET;
        end else if (wr_end) begin
            if (cap_word_q) begin
                ctrl_q <= cap_data_q;
            end else if (cap_data_q[`ADCP_LOW_BYTE_W]) begin
                ctrl_q[`ADCP_WORD_W-1:`ADCP_LOW_BYTE_W] <= cap_data_q[`ADCP_HIGH_NIB_W-1:0];
            end else begin
                ctrl_q[`ADCP_LOW_BYTE_W-1:0] <= cap_data_q[`ADCP_LOW_BYTE_W-1:0];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            commit_q <= 1'b0;
        end else begin
            commit_q <= wr_end;
        end
    end

    assign ctrl_word = ctrl_q;

    // ****************************************************************
    // Conversion timing.
    // ****************************************************************

    logic [CW-1:0] conv_cnt_q;
    logic          busy_q;
    logic          eoc_q;
    logic          conv_start;

    adcp_pkg::adcp_pstate_t state_q;

    assign conv_start = convert_start_n_fall & ~busy_q & (state_q == adcp_pkg::ST_ACTIVE);

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            conv_cnt_q <= '0;
            busy_q     <= 1'b0;
        end else if (conv_start) begin
            conv_cnt_q <= CW'(CONV_CYCLES);
            busy_q     <= 1'b1;
        end else if (busy_q) begin
            conv_cnt_q <= conv_cnt_q - CW'(1);
            if (conv_cnt_q <= CW'(1)) begin
                busy_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            eoc_q <= 1'b0;
        end else begin
            eoc_q <= busy_q & (conv_cnt_q <= CW'(1)) & ~conv_start;
        end
    end

    assign busy = busy_q;

    // ****************************************************************
    // Power-mode events.
    // ****************************************************************

    adcp_pkg::adcp_pmode_t pm;
    logic                  go_full;
    logic                  leave_full;
    logic                  go_shdn;
    logic                  go_stby;
    logic                  wake_up;

    assign pm = adcp_pkg::adcp_pmode_t'({ctrl_q[`ADCP_PM_HI_POS], ctrl_q[`ADCP_PM_LO_POS]});

    assign go_full    = commit_q & (pm == adcp_pkg::PM_FULL_SHDN) & (state_q != adcp_pkg::ST_FULL_OFF);
    assign leave_full = commit_q & (pm != adcp_pkg::PM_FULL_SHDN) & (state_q == adcp_pkg::ST_FULL_OFF);
    assign go_shdn    = eoc_q & ~commit_q & (state_q == adcp_pkg::ST_ACTIVE) & (pm == adcp_pkg::PM_AUTO_SHDN);
    assign go_stby    = eoc_q & ~commit_q & (state_q == adcp_pkg::ST_ACTIVE) & (pm == adcp_pkg::PM_AUTO_STBY);
    assign wake_up    = convert_start_n_rise & ~commit_q
                      & ((state_q == adcp_pkg::ST_SHUTDOWN) | (state_q == adcp_pkg::ST_STANDBY));

    // ****************************************************************
    // Power state machine.
    // ****************************************************************

    // state sampled at writes and ends.
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            state_q <= adcp_pkg::ST_ACTIVE;
        end else begin
            unique case (state_q)
                adcp_pkg::ST_ACTIVE: begin
                    if (go_full) begin
                        state_q <= adcp_pkg::ST_FULL_OFF;
                    end else if (go_shdn) begin
                        state_q <= adcp_pkg::ST_SHUTDOWN;
                    end else if (go_stby) begin
                        state_q <= adcp_pkg::ST_STANDBY;
                    end
                end
                adcp_pkg::ST_SHUTDOWN,
                adcp_pkg::ST_STANDBY: begin
                    if (go_full) begin
                        state_q <= adcp_pkg::ST_FULL_OFF;
                    end else if (wake_up) begin
                        state_q <= adcp_pkg::ST_ACTIVE;
                    end
                end
                adcp_pkg::ST_FULL_OFF: begin
                    if (leave_full) begin
                        state_q <= adcp_pkg::ST_ACTIVE;
                    end
                end
                default: begin
                    state_q <= adcp_pkg::ST_ACTIVE;
                end
            endcase
        end
    end

    assign power_state  = state_q;
    assign core_powered = (state_q == adcp_pkg::ST_ACTIVE);
    assign ref_powered  = (state_q == adcp_pkg::ST_ACTIVE) | (state_q == adcp_pkg::ST_STANDBY);

    // ****************************************************************
    // Track-and-hold control.
    // ****************************************************************

    logic track_q;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            track_q <= 1'b0;
        end else if (go_full) begin
            track_q <= 1'b0;
        end else if (leave_full) begin
            track_q <= 1'b1;
        end else if (go_shdn | go_stby) begin
            track_q <= 1'b0;
        end else if (eoc_q & (state_q == adcp_pkg::ST_ACTIVE)) begin
            track_q <= 1'b1;
        end else if (conv_start) begin
            track_q <= 1'b0;
        end else if (wake_up | (convert_start_n_rise & (state_q == adcp_pkg::ST_ACTIVE) & ~busy_q)) begin
            track_q <= 1'b1;
        end
    end

    assign track_mode = track_q;

    // ****************************************************************
    // Power-up wait timer.
    // ****************************************************************

    adcp_wake_if #(.W(WAKE_W)) wake ();

    logic              wake_start_q;
    logic [WAKE_W-1:0] wake_cycles_q;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            wake_start_q  <= 1'b0;
            wake_cycles_q <= '0;
        end else begin
            wake_start_q <= leave_full | wake_up;
            if (leave_full | (wake_up & (state_q == adcp_pkg::ST_SHUTDOWN))) begin
                wake_cycles_q <= WAKE_W'(SHDN_WAKE_CYCLES);
            end else if (ref_ext_s) begin
                wake_cycles_q <= WAKE_W'(STBY_EXT_CYCLES);
            end else begin
                wake_cycles_q <= WAKE_W'(STBY_INT_CYCLES);
            end
        end
    end

    assign wake.start  = wake_start_q;
    assign wake.cycles = wake_cycles_q;

    adcp_wake_timer #(
        .W (WAKE_W)
    ) u_wake (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .wake     (wake.timer)
    );

    assign powerup_pending = wake.busy | wake_start_q;

endmodule : adcp_ctrl_power

// [adcp_consts.svh]
// Constants for the control-word write path and power-mode controller of the converter.
// Operation
// - Word mode takes all twelve control bits in one write, line zero lowest.
// - Byte mode builds the twelve-bit word from two writes on lines zero to seven.
// - In byte mode line eight is high byte enable; line zero becomes bit eight.
// - Write data enters the control register at the write strobe rising edge.
// - A write happens only while chip select and write strobe are both low.
// - Two power bits select normal, autoshutdown, autostandby or full shutdown.
// - Reset sets the power bits to normal, fully powered at all times.
// - After reset track-and-hold holds until the first convert-start rising edge.
// - Autoshutdown powers everything down and holds at each conversion end.
// - Convert-start rising edge wakes from autoshutdown to track; host waits ten ms.
// - Autostandby keeps only the reference powered and holds at conversion end.
// - Convert-start rising edge wakes from standby; host waits 600 ns or 7 us.
// - Writing full shutdown powers down and holds at the write strobe end.
// - Writing normal from full shutdown powers up and tracks; host waits ten ms.
// - Convert-start falling edge starts a conversion; busy high until it ends.
`ifndef ADCP_CONSTS_SVH
`define ADCP_CONSTS_SVH

`define ADCP_WORD_W          12
`define ADCP_LOW_BYTE_W      8
`define ADCP_HIGH_NIB_W      4
`define ADCP_PM_HI_POS       11
`define ADCP_PM_LO_POS       10
`define ADCP_CTRL_RESET      12'h000
`define ADCP_CLK_NS          10
`define ADCP_T_SHDN_WAKE_NS  10000000
`define ADCP_T_STBY_INT_NS   7000
`define ADCP_T_STBY_EXT_NS   600
`define ADCP_CONV_CYCLES     14
`define ADCP_WAKE_W          20

`endif

// [adcp_pkg.sv]
// Types shared by the control-word write path and power-mode controller.
package adcp_pkg;

    typedef enum logic [3:0] {
        ST_ACTIVE   = 4'h1,
        ST_SHUTDOWN = 4'h2,
        ST_STANDBY  = 4'h4,
        ST_FULL_OFF = 4'h8
    } adcp_pstate_t;

    typedef enum logic [1:0] {
        PM_NORMAL    = 2'h0,
        PM_AUTO_SHDN = 2'h1,
        PM_AUTO_STBY = 2'h2,
        PM_FULL_SHDN = 2'h3
    } adcp_pmode_t;

endpackage : adcp_pkg

// [adcp_wake_if.sv]
// Interface between the power controller and its power-up wait timer.
`timescale 1ns/100ps
interface adcp_wake_if #(
    parameter int W = 20
);
    logic         start;
    logic [W-1:0] cycles;
    logic         busy;

    modport ctrl  (output start, output cycles, input busy);
    modport timer (input start, input cycles, output busy);
endinterface : adcp_wake_if

// [adcp_sync.sv]
// Two-stage synchroniser for a group of pin inputs.
`timescale 1ns/100ps
module adcp_sync #(
    parameter int           W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    // Clock and reset.
    input  wire logic         core_clk,
    input  wire logic         reset_n,
    // Pins and their synchronised copies.
    input  wire logic [W-1:0] pins_in,
    output logic      [W-1:0] pins_sync
);
    logic [W-1:0] stage1_q;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            stage1_q  <= RST;
            pins_sync <= RST;
        end else begin
            stage1_q  <= pins_in;
            pins_sync <= stage1_q;
        end
    end
endmodule : adcp_sync

// [adcp_wake_timer.sv]
// Down-counter that measures the power-up wait after a wake.
`timescale 1ns/100ps
module adcp_wake_timer #(
    parameter int W = 20
) (
    // Clock and reset.
    input  wire logic   core_clk,
    input  wire logic   reset_n,
    // Start request, length and busy flag.
    adcp_wake_if.timer  wake
);
    logic [W-1:0] cnt_q;
    logic         busy_q;

    initial begin
        if (W < 2) begin
            $error("adcp_wake_timer: counter width too small");
        end
    end

    assign wake.busy = busy_q;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            cnt_q  <= '0;
            busy_q <= 1'b0;
        end else if (wake.start) begin
            cnt_q  <= wake.cycles;
            busy_q <= 1'b1;
        end else if (busy_q) begin
            cnt_q <= cnt_q - W'(1);
            if (cnt_q <= W'(1)) begin
                busy_q <= 1'b0;
            end
        end
    end
endmodule : adcp_wake_timer

// [adcp_cp_sva.sv]
// Assertion checker for the control-word write path and power-mode controller.
`timescale 1ns/100ps
`include "adcp_consts.svh"
module adcp_cp_sva #(
    parameter int CONV_CYCLES = 14
) (
    // Clock and reset.
    input wire logic                    core_clk,
    input wire logic                    reset_n,
    // Host pins.
    input wire logic                    cs_n,
    input wire logic                    wr_n,
    input wire logic                    convert_start_n,
    // Status.
    input wire logic                    busy,
    input wire logic                    track_mode,
    input wire logic                    core_powered,
    input wire logic                    ref_powered,
    input wire logic                    powerup_pending,
    input wire adcp_pkg::adcp_pstate_t  power_state,
    input wire logic [`ADCP_WORD_W-1:0] ctrl_word
);
    logic [5:0] conv_len_q;
    logic [3:0] idle_q;

    // ********************************
    // Helper counters
    // ********************************
    always_ff @(posedge core_clk) begin
        if (!reset_n || !busy) begin
            conv_len_q <= 6'h00;
        end else begin
            conv_len_q <= conv_len_q + 6'h01;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n || (!cs_n && !wr_n)) begin
            idle_q <= 4'h0;
        end else if (idle_q != 4'hF) begin
            idle_q <= idle_q + 4'h1;
        end
    end

    // ********************************
    // Assertions
    // ********************************
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    chk_reset_values: assert property ($rose(reset_n) |-> power_state == adcp_pkg::ST_ACTIVE
        && ctrl_word == 12'h000 && !busy && !track_mode) else $error("reset state wrong");
    chk_busy_length: assert property ($fell(busy) |-> conv_len_q == CONV_CYCLES)
        else $error("conversion length wrong");
    chk_conv_start: assert property ($rose(busy) |-> !$past(convert_start_n, 2)
        && $past(power_state) == adcp_pkg::ST_ACTIVE && !track_mode) else $error("bad conversion start");
    chk_end_mode: assert property ($fell(busy) |-> ##1 power_state == (ctrl_word[11:10] == 2'b01 ?
        adcp_pkg::ST_SHUTDOWN : ctrl_word[11:10] == 2'b10 ? adcp_pkg::ST_STANDBY : adcp_pkg::ST_ACTIVE))
        else $error("wrong state after conversion");
    chk_sleep_outputs: assert property (power_state != adcp_pkg::ST_ACTIVE |-> !core_powered
        && !track_mode && ref_powered == (power_state == adcp_pkg::ST_STANDBY)) else $error("sleep outputs wrong");
    chk_awake_outputs: assert property (power_state == adcp_pkg::ST_ACTIVE |-> core_powered && ref_powered)
        else $error("active outputs wrong");
    chk_ctrl_quiet: assert property (idle_q >= 4'h6 |-> $stable(ctrl_word))
        else $error("control word changed without write");
    chk_full_entry: assert property ($changed(ctrl_word) && ctrl_word[11:10] == 2'b11
        |=> power_state == adcp_pkg::ST_FULL_OFF) else $error("full shutdown not entered");
    chk_full_exit: assert property ($changed(ctrl_word) && ctrl_word[11:10] == 2'b00
        && $past(power_state) == adcp_pkg::ST_FULL_OFF |=> power_state == adcp_pkg::ST_ACTIVE && track_mode)
        else $error("full shutdown exit wrong");
    chk_wake_active: assert property ($rose(powerup_pending) |-> power_state == adcp_pkg::ST_ACTIVE
        && track_mode) else $error("wake without active tracking");

    cover property ($fell(busy));
    cover property (power_state == adcp_pkg::ST_STANDBY);
    cover property (power_state == adcp_pkg::ST_FULL_OFF);
    cover property ($fell(powerup_pending));
endmodule : adcp_cp_sva

bind adcp_ctrl_power adcp_cp_sva #(.CONV_CYCLES(CONV_CYCLES)) chk_u (.core_clk(core_clk), .reset_n(reset_n),
    .cs_n(cs_n), .wr_n(wr_n), .convert_start_n(convert_start_n), .busy(busy), .track_mode(track_mode),
    .core_powered(core_powered), .ref_powered(ref_powered), .powerup_pending(powerup_pending),
    .power_state(power_state), .ctrl_word(ctrl_word));

// [adcp_host_model.sv]
// Host processor model that drives the parallel write pins and convert start.
`timescale 1ns/100ps
module adcp_host_model (
    // Clock.
    input  wire logic  core_clk,
    // Parallel write pins.
    output logic       cs_n,
    output logic       wr_n,
    output logic       word_sel,
    output logic [7:0] data_lines_lo,
    output logic       data8_or_byte_sel_line,
    output logic [2:0] data_lines_hi,
    // Conversion control pins.
    output logic       convert_start_n,
    output logic       ref_is_external
);
    initial begin
        {cs_n, wr_n, word_sel} = 3'b111;
        convert_start_n = 1'b0;
        ref_is_external = 1'b0;
    end

    task automatic put(input logic ws, input logic l8, input logic [2:0] hi, input logic [7:0] lo,
                       input logic csv);
        @(posedge core_clk);
        {cs_n, wr_n, word_sel} <= {csv, 1'b0, ws};
        {data_lines_hi, data8_or_byte_sel_line, data_lines_lo} <= {hi, l8, lo};
        repeat (5) @(posedge core_clk);
        {cs_n, wr_n} <= 2'b11;
        repeat (2) @(posedge core_clk);
        // Released lines move away from the last value.
        {data_lines_hi, data8_or_byte_sel_line, data_lines_lo} <= ~{hi, l8, lo};
        repeat (3) @(posedge core_clk);
    endtask : put

    task automatic put_bytes(input logic [11:0] w);
        put(1'b0, 1'b0, 3'h0, w[7:0], 1'b0);
        put(1'b0, 1'b1, 3'h0, {4'h0, w[11:8]}, 1'b0);
    endtask : put_bytes

    task automatic cv(input logic v);
        @(posedge core_clk);
        convert_start_n <= v;
    endtask : cv

    task automatic set_ref(input logic v);
        @(posedge core_clk);
        ref_is_external <= v;
    endtask : set_ref
endmodule : adcp_host_model

// [tb_top.sv]
// Self-checking testbench for the control-word write path and power-mode controller.
`timescale 1ns/100ps
`include "adcp_consts.svh"
module tb_top;
    localparam int CONV = 14;
    localparam int SHDN = 50;
    localparam int EXTW = `ADCP_T_STBY_EXT_NS / `ADCP_CLK_NS;
    localparam int INTW = `ADCP_T_STBY_INT_NS / `ADCP_CLK_NS;
    logic                   core_clk = 1'b0;
    logic                   reset_n;
    logic                   cs_n;
    logic                   wr_n;
    logic                   word_sel;
    logic [7:0]             data_lines_lo;
    logic                   data8_or_byte_sel_line;
    logic [2:0]             data_lines_hi;
    logic                   convert_start_n;
    logic                   ref_is_external;
    logic                   busy;
    logic                   track_mode;
    logic                   core_powered;
    logic                   ref_powered;
    logic                   powerup_pending;
    adcp_pkg::adcp_pstate_t power_state;
    logic [11:0]            ctrl_word;
    int                     mismatches;
    int                     comparisons;

    always #5 core_clk = ~core_clk;

    adcp_host_model host_u (.core_clk(core_clk), .cs_n(cs_n), .wr_n(wr_n), .word_sel(word_sel),
        .data_lines_lo(data_lines_lo), .data8_or_byte_sel_line(data8_or_byte_sel_line),
        .data_lines_hi(data_lines_hi), .convert_start_n(convert_start_n), .ref_is_external(ref_is_external));

    adcp_ctrl_power #(.CONV_CYCLES(CONV), .SHDN_WAKE_CYCLES(SHDN)) dut_u (.core_clk(core_clk),
        .reset_n(reset_n), .cs_n(cs_n), .wr_n(wr_n), .word_sel(word_sel), .data_lines_lo(data_lines_lo),
        .data8_or_byte_sel_line(data8_or_byte_sel_line), .data_lines_hi(data_lines_hi),
        .convert_start_n(convert_start_n), .ref_is_external(ref_is_external), .busy(busy),
        .track_mode(track_mode), .core_powered(core_powered), .ref_powered(ref_powered),
        .powerup_pending(powerup_pending), .power_state(power_state), .ctrl_word(ctrl_word));

    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick

    task automatic st(input logic [6:0] exp);
        check(12'({power_state, track_mode, core_powered, ref_powered}), 12'(exp));
    endtask : st

    task automatic wr12(input logic [11:0] w);
        host_u.put(1'b1, w[8], w[11:9], w[7:0], 1'b0);
        tick(0);
    endtask : wr12

    task automatic conv();
        int n;
        n = 0;
        host_u.cv(1'b1);
        tick(3);
        host_u.cv(1'b0);
        tick(3);
        check(12'({busy, track_mode}), 12'h002);
        while (busy === 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
        check(12'(n), 12'(CONV));
        tick(2);
    endtask : conv

    task automatic pend(input int w);
        int n;
        n = 0;
        tick(1);
        while (powerup_pending === 1'b1 && n < 2000) begin
            tick(1);
            n++;
        end
        check(12'(n >= w - 2 && n <= w + 2), 12'h001);
    endtask : pend

    task automatic t_reset();
        host_u.cv(1'b0);
        @(posedge core_clk);
        reset_n <= 1'b0;
        repeat (12) @(posedge core_clk);
        reset_n <= 1'b1;
        tick(6);
        check(ctrl_word, 12'h000);
        st({4'h1, 3'b011});
        check(12'({busy, powerup_pending}), 12'h000);
        host_u.cv(1'b1);
        tick(3);
        check(12'(track_mode), 12'h001);
        $display("test reset done");
    endtask : t_reset

    task automatic t_word();
        wr12(12'h2A5);
        check(ctrl_word, 12'h2A5);
        host_u.put(1'b1, 1'b0, 3'h0, 8'hF0, 1'b1);
        tick(0);
        check(ctrl_word, 12'h2A5);
        conv();
        st({4'h1, 3'b111});
        $display("test word done");
    endtask : t_word

    task automatic t_byte();
        host_u.put(1'b0, 1'b0, 3'h0, 8'h5C, 1'b0);
        tick(0);
        check(ctrl_word, 12'h25C);
        host_u.put_bytes(12'h1A7);
        tick(0);
        check(ctrl_word, 12'h1A7);
        $display("test byte done");
    endtask : t_byte

    task automatic t_auto();
        for (int i = 0; i < 3; i++) begin
            host_u.set_ref(i == 1);
            wr12({(i == 0) ? 2'h1 : 2'h2, 10'h000});
            conv();
            st({(i == 0) ? 4'h2 : 4'h4, 2'b00, i != 0});
            tick(20);
            st({(i == 0) ? 4'h2 : 4'h4, 2'b00, i != 0});
            host_u.cv(1'b1);
            tick(3);
            st({4'h1, 3'b111});
            pend((i == 0) ? SHDN : (i == 1) ? EXTW : INTW);
        end
        $display("test auto modes done");
    endtask : t_auto

    task automatic t_full();
        wr12(12'hC00);
        st({4'h8, 3'b000});
        host_u.cv(1'b0);
        tick(6);
        check(12'(busy), 12'h000);
        host_u.cv(1'b1);
        tick(6);
        st({4'h8, 3'b000});
        wr12(12'h000);
        st({4'h1, 3'b111});
        pend(SHDN);
        $display("test full shutdown done");
    endtask : t_full

    task automatic results();
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results

    initial begin
        mismatches = 0;
        comparisons = 0;
        reset_n <= 1'b0;
        t_reset();
        t_word();
        t_byte();
        t_auto();
        t_full();
        wr12(12'h800);
        t_reset();
        results();
    end

    // Watchdog well past the fewer than two thousand cycles the tests need.
    initial begin
        #200000;
        mismatches++;
        results();
    end
endmodule : tb_top
